// ===== src/bbc_pkg.sv
// package: register map, field positions, reset values and carrier types of the calibration block
package bbc_pkg;

  // register byte offsets on the AHB-Lite bus (register n sits at 4*n)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_LOOPBACK = 8'h04;
  localparam logic [7:0] OFS_FILTER = 8'h08;
  localparam logic [7:0] OFS_TXBIAS = 8'h0C;
  localparam logic [7:0] OFS_TEMP = 8'h10;
  localparam logic [7:0] OFS_CAL = 8'h14;
  localparam logic [7:0] OFS_MANUAL = 8'h1C;

  // field positions
  localparam int POS_CONV_COMPLETE = 5;
  localparam int POS_OUT_OF_RANGE = 6;
  localparam int POS_RESULT_LO = 22;
  localparam int POS_LOOPBACK_ON = 18;
  localparam int POS_LOOPBACK_ATT = 19;
  localparam int POS_CORNER_LO = 16;
  localparam int POS_BYPASS = 23;
  localparam int POS_TX_Q_LO = 19;
  localparam int POS_TX_I_LO = 25;
  localparam int POS_TX_BIAS = 31;
  localparam int POS_CONV_GO = 5;
  localparam int POS_CONV_OFF = 21;
  localparam int POS_SENSOR_OFF = 22;
  localparam int POS_RX_GO = 5;
  localparam int POS_RX_RANGE_LO = 12;
  localparam int POS_RX_DIV_LO = 14;
  localparam int POS_XPOL_GO = 18;
  localparam int POS_XPOL_RANGE_LO = 25;
  localparam int POS_XPOL_DIV_LO = 27;
  localparam int POS_MAN_I_LO = 5;
  localparam int POS_MAN_Q_LO = 13;
  localparam int POS_SOURCE = 21;

  // values after reset
  localparam logic [7:0] CORR_HALF_SCALE = 8'h80;
  localparam logic [5:0] TX_OFS_MID = 6'h20;
  localparam logic [6:0] CORNER_RST = 7'h00;
  localparam logic SOURCE_RST = 1'b1;
  localparam logic POWER_OFF_RST = 1'b1;

  // counts
  localparam logic [3:0] CAL_LAST_TICK = 4'hC;
  localparam logic [7:0] CAL_FIRST_STEP = 8'h40;
  localparam logic [3:0] ADC_DIV_LAST = 4'hF;
  localparam logic [7:0] ADC_FIRST_TRIAL = 8'h80;

  typedef enum logic [0:0] {
    BBC_IDLE = 1'b0,
    BBC_RUN = 1'b1
  } bbc_state_t;

  // static analog controls
  typedef struct packed {
    logic [6:0] rx_filter_corner_code;
    logic rx_filter_bypass;
    logic loopback_on;
    logic loopback_attenuate;
    logic tx_internal_bias_on;
    logic [5:0] tx_i_offset_dac;
    logic [5:0] tx_q_offset_dac;
    logic temp_sensor_on;
    logic temp_conv_on;
  } bbc_ctrl_t;

  // one correction DAC pair
  typedef struct packed {
    logic [1:0] range;
    logic [7:0] i_code;
    logic [7:0] q_code;
  } bbc_corr_t;

endpackage : bbc_pkg

// ===== src/bbc_top.sv
// design: dc-offset calibration sequencers, temperature converter control and AHB-Lite registers
//
// Contract
// - seven-bit filter corner, all ones lowest
// - bypass bit skips receive low-pass filter
// - receive start bit runs calibration, self-clears
// - cross-polarization start bit, same self-clear
// - each calibration tick samples offset, updates
// - finish after thirteenth tick, clear start
// - calibration tick from divided reference clock
// - two-bit DAC full-scale fields per chain
// - correction codes start at half scale
// - source bit picks calibrated or manual receive codes
// - manual I and Q offset bytes
// - calibrated codes held until next start
// - sensor enabled when its off bit clear
// - converter enabled when its off bit clear
// - conversion start bit, self-clears at end
// - converter clocked at reference divided sixteen
// - eight-bit result into status register
// - complete flag set after conversion
// - out-of-range flag from converter input
// - transmit bias enable and offset DACs
// - loopback enable and attenuation select
`timescale 1ns/100ps
`default_nettype none

module bbc_top (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  input wire logic [3:0] OFFSET_HIGH_I,
  input wire logic TEMP_ABOVE_TRIAL_I,
  input wire logic TEMP_RANGE_BAD_I,
  output logic [7:0] TEMP_TRIAL_O,
  output logic TEMP_SAMPLE_O,
  output bbc_pkg::bbc_ctrl_t CTRL_O,
  output bbc_pkg::bbc_corr_t RX_CORR_O,
  output bbc_pkg::bbc_corr_t XPOL_CORR_O
);

  // one step of the offset search: a positive offset lowers the code, saturating at the ends
  function automatic logic [7:0] search_next(input logic [7:0] code, input logic [7:0] step,
                                             input logic high);
    logic [8:0] sum;
    sum = 9'h000;
    if (high) begin
      sum = (code > step) ? ({1'b0, code} - {1'b0, step}) : 9'h000;
    end else begin
      sum = {1'b0, code} + {1'b0, step};
      if (sum[8]) begin
        sum = 9'h0FF;
      end
    end
    return sum[7:0];
  endfunction : search_next

  // terminal count of the calibration divider: ratio 2 << sel
  function automatic logic [7:0] cal_div_last(input logic [2:0] sel);
    logic [8:0] ratio;
    ratio = 9'h002 << sel;
    return 8'(ratio - 9'h001);
  endfunction : cal_div_last

  // bus phase registers
  logic ph_valid;
  logic ph_write;
  logic ph_word;
  logic [7:0] ph_addr;
  logic rd_wait;
  logic wr_en;
  logic rd_load;
  logic [31:0] rd_mux;

  // software fields
  logic [6:0] corner_code;
  logic bypass;
  logic lb_on;
  logic lb_att;
  logic tx_bias;
  logic [5:0] tx_i;
  logic [5:0] tx_q;
  logic sensor_off;
  logic conv_off;
  logic conv_go;
  logic [1:0] cal_go;
  logic [1:0] dac_range [2];
  logic [2:0] div_sel [2];
  logic [7:0] manual_i_offset;
  logic [7:0] manual_q_offset;
  logic corr_source_select;

  // calibration sequencers, index 0 receive, 1 cross-polarization
  bbc_pkg::bbc_state_t cal_state [2];
  logic [7:0] div_cnt [2];
  logic [3:0] tick_cnt [2];
  logic [7:0] step [2];
  logic [7:0] auto_i [2];
  logic [7:0] auto_q [2];
  logic [1:0] cal_start;
  logic [1:0] cal_tick;
  logic [1:0] cal_done;

  // temperature converter
  bbc_pkg::bbc_state_t adc_state;
  logic [3:0] adc_div;
  logic [7:0] trial;
  logic [7:0] mask;
  logic [7:0] temp_result;
  logic temp_conv_complete;
  logic temp_input_out_of_range;
  logic adc_start;
  logic adc_tick;
  logic adc_done;

  // address phase is taken only when the bus is ready; a read holds the bus one extra cycle
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_word <= 1'b0;
      ph_addr <= 8'h00;
    end else if (HREADY_I) begin
      ph_valid <= HSEL_I && HTRANS_I[1];
      ph_write <= HWRITE_I;
      ph_word <= (HSIZE_I == 3'h2) && (HADDR_I[31:8] == 24'h000000);
      ph_addr <= HADDR_I[7:0];
    end
  end

  assign rd_load = ph_valid && !ph_write && !rd_wait;
  assign wr_en = ph_valid && ph_write && ph_word;
  assign HREADYOUT_O = !rd_load;
  assign HRESP_O = 1'b0;

  // wait state gives the read data a flop without racing a write in the previous data phase
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_wait <= 1'b0;
      HRDATA_O <= 32'h00000000;
    end else begin
      rd_wait <= rd_load;
      if (rd_load) begin
        HRDATA_O <= ph_word ? rd_mux : 32'h00000000;
      end
    end
  end

  // read view; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (ph_addr)
      bbc_pkg::OFS_STATUS: begin
        rd_mux[bbc_pkg::POS_RESULT_LO +: 8] = temp_result;
        rd_mux[bbc_pkg::POS_CONV_COMPLETE] = temp_conv_complete;
        rd_mux[bbc_pkg::POS_OUT_OF_RANGE] = temp_input_out_of_range;
      end
      bbc_pkg::OFS_LOOPBACK: begin
        rd_mux[bbc_pkg::POS_LOOPBACK_ON] = lb_on;
        rd_mux[bbc_pkg::POS_LOOPBACK_ATT] = lb_att;
      end
      bbc_pkg::OFS_FILTER: begin
        rd_mux[bbc_pkg::POS_CORNER_LO +: 7] = corner_code;
        rd_mux[bbc_pkg::POS_BYPASS] = bypass;
      end
      bbc_pkg::OFS_TXBIAS: begin
        rd_mux[bbc_pkg::POS_TX_Q_LO +: 6] = tx_q;
        rd_mux[bbc_pkg::POS_TX_I_LO +: 6] = tx_i;
        rd_mux[bbc_pkg::POS_TX_BIAS] = tx_bias;
      end
      bbc_pkg::OFS_TEMP: begin
        rd_mux[bbc_pkg::POS_CONV_GO] = conv_go;
        rd_mux[bbc_pkg::POS_CONV_OFF] = conv_off;
        rd_mux[bbc_pkg::POS_SENSOR_OFF] = sensor_off;
      end
      bbc_pkg::OFS_CAL: begin
        rd_mux[bbc_pkg::POS_RX_GO] = cal_go[0];
        rd_mux[bbc_pkg::POS_RX_RANGE_LO +: 2] = dac_range[0];
        rd_mux[bbc_pkg::POS_RX_DIV_LO +: 3] = div_sel[0];
        rd_mux[bbc_pkg::POS_XPOL_GO] = cal_go[1];
        rd_mux[bbc_pkg::POS_XPOL_RANGE_LO +: 2] = dac_range[1];
        rd_mux[bbc_pkg::POS_XPOL_DIV_LO +: 3] = div_sel[1];
      end
      bbc_pkg::OFS_MANUAL: begin
        rd_mux[bbc_pkg::POS_MAN_I_LO +: 8] = manual_i_offset;
        rd_mux[bbc_pkg::POS_MAN_Q_LO +: 8] = manual_q_offset;
        rd_mux[bbc_pkg::POS_SOURCE] = corr_source_select;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // plain static fields of the loopback, filter, transmit bias and power-down registers
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      corner_code <= bbc_pkg::CORNER_RST;
      bypass <= 1'b0;
      lb_on <= 1'b0;
      lb_att <= 1'b0;
      tx_bias <= 1'b0;
      tx_i <= bbc_pkg::TX_OFS_MID;
      tx_q <= bbc_pkg::TX_OFS_MID;
      sensor_off <= bbc_pkg::POWER_OFF_RST;
      conv_off <= bbc_pkg::POWER_OFF_RST;
    end else if (wr_en) begin
      case (ph_addr)
        bbc_pkg::OFS_LOOPBACK: begin
          lb_on <= HWDATA_I[bbc_pkg::POS_LOOPBACK_ON];
          lb_att <= HWDATA_I[bbc_pkg::POS_LOOPBACK_ATT];
        end
        bbc_pkg::OFS_FILTER: begin
          corner_code <= HWDATA_I[bbc_pkg::POS_CORNER_LO +: 7];
          bypass <= HWDATA_I[bbc_pkg::POS_BYPASS];
        end
        bbc_pkg::OFS_TXBIAS: begin
          tx_bias <= HWDATA_I[bbc_pkg::POS_TX_BIAS];
          tx_i <= HWDATA_I[bbc_pkg::POS_TX_I_LO +: 6];
          tx_q <= HWDATA_I[bbc_pkg::POS_TX_Q_LO +: 6];
        end
        bbc_pkg::OFS_TEMP: begin
          sensor_off <= HWDATA_I[bbc_pkg::POS_SENSOR_OFF];
          conv_off <= HWDATA_I[bbc_pkg::POS_CONV_OFF];
        end
        default: begin
          corner_code <= corner_code;
        end
      endcase
    end
  end

  // calibration setup fields and manual offsets
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dac_range[0] <= 2'h0;
      dac_range[1] <= 2'h0;
      div_sel[0] <= 3'h0;
      div_sel[1] <= 3'h0;
      manual_i_offset <= bbc_pkg::CORR_HALF_SCALE;
      manual_q_offset <= bbc_pkg::CORR_HALF_SCALE;
      corr_source_select <= bbc_pkg::SOURCE_RST;
    end else if (wr_en && (ph_addr == bbc_pkg::OFS_CAL)) begin
      dac_range[0] <= HWDATA_I[bbc_pkg::POS_RX_RANGE_LO +: 2];
      dac_range[1] <= HWDATA_I[bbc_pkg::POS_XPOL_RANGE_LO +: 2];
      div_sel[0] <= HWDATA_I[bbc_pkg::POS_RX_DIV_LO +: 3];
      div_sel[1] <= HWDATA_I[bbc_pkg::POS_XPOL_DIV_LO +: 3];
    end else if (wr_en && (ph_addr == bbc_pkg::OFS_MANUAL)) begin
      manual_i_offset <= HWDATA_I[bbc_pkg::POS_MAN_I_LO +: 8];
      manual_q_offset <= HWDATA_I[bbc_pkg::POS_MAN_Q_LO +: 8];
      corr_source_select <= HWDATA_I[bbc_pkg::POS_SOURCE];
    end
  end

  // a write of one to a start bit restarts that chain, even mid-run
  assign cal_start[0] = wr_en && (ph_addr == bbc_pkg::OFS_CAL) && HWDATA_I[bbc_pkg::POS_RX_GO];
  assign cal_start[1] = wr_en && (ph_addr == bbc_pkg::OFS_CAL) && HWDATA_I[bbc_pkg::POS_XPOL_GO];

  // start bits: a new start in the finishing cycle wins over the self-clear
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cal_go <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cal_start[c]) begin
          cal_go[c] <= 1'b1;
        end else if (cal_done[c]) begin
          cal_go[c] <= 1'b0;
        end
      end
    end
  end

  // per-chain tick: each chain divides the reference by its own select, so the two never share
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cal_tick[c] = (cal_state[c] == bbc_pkg::BBC_RUN) && (div_cnt[c] == cal_div_last(div_sel[c]));
      cal_done[c] = cal_tick[c] && (tick_cnt[c] == bbc_pkg::CAL_LAST_TICK);
    end
  end

  // offset search: step halves from quarter scale down to one lsb, then keeps tracking
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int c = 0; c < 2; c++) begin
        cal_state[c] <= bbc_pkg::BBC_IDLE;
        div_cnt[c] <= 8'h00;
        tick_cnt[c] <= 4'h0;
        step[c] <= bbc_pkg::CAL_FIRST_STEP;
        auto_i[c] <= bbc_pkg::CORR_HALF_SCALE;
        auto_q[c] <= bbc_pkg::CORR_HALF_SCALE;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cal_start[c]) begin
          cal_state[c] <= bbc_pkg::BBC_RUN;
          div_cnt[c] <= 8'h00;
          tick_cnt[c] <= 4'h0;
          step[c] <= bbc_pkg::CAL_FIRST_STEP;
          auto_i[c] <= bbc_pkg::CORR_HALF_SCALE;
          auto_q[c] <= bbc_pkg::CORR_HALF_SCALE;
        end else begin
          case (cal_state[c])
            bbc_pkg::BBC_RUN: begin
              div_cnt[c] <= cal_tick[c] ? 8'h00 : div_cnt[c] + 8'h01;
              if (cal_tick[c]) begin
                auto_i[c] <= search_next(auto_i[c], step[c], OFFSET_HIGH_I[2 * c]);
                auto_q[c] <= search_next(auto_q[c], step[c], OFFSET_HIGH_I[2 * c + 1]);
                step[c] <= (step[c] > 8'h01) ? (step[c] >> 1) : 8'h01;
                tick_cnt[c] <= tick_cnt[c] + 4'h1;
                if (cal_done[c]) begin
                  cal_state[c] <= bbc_pkg::BBC_IDLE;
                end
              end
            end
            default: begin
              cal_state[c] <= bbc_pkg::BBC_IDLE; // codes held while idle
            end
          endcase
        end
      end
    end
  end

  // correction DAC drive; only the receive chain has a manual override
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RX_CORR_O <= '{range: 2'h0, i_code: bbc_pkg::CORR_HALF_SCALE, q_code: bbc_pkg::CORR_HALF_SCALE};
      XPOL_CORR_O <= '{range: 2'h0, i_code: bbc_pkg::CORR_HALF_SCALE, q_code: bbc_pkg::CORR_HALF_SCALE};
    end else begin
      RX_CORR_O.range <= dac_range[0];
      RX_CORR_O.i_code <= corr_source_select ? auto_i[0] : manual_i_offset;
      RX_CORR_O.q_code <= corr_source_select ? auto_q[0] : manual_q_offset;
      XPOL_CORR_O.range <= dac_range[1];
      XPOL_CORR_O.i_code <= auto_i[1];
      XPOL_CORR_O.q_code <= auto_q[1];
    end
  end

  // static controls out
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CTRL_O <= '0;
    end else begin
      CTRL_O.rx_filter_corner_code <= corner_code;
      CTRL_O.rx_filter_bypass <= bypass;
      CTRL_O.loopback_on <= lb_on;
      CTRL_O.loopback_attenuate <= lb_att;
      CTRL_O.tx_internal_bias_on <= tx_bias;
      CTRL_O.tx_i_offset_dac <= tx_i;
      CTRL_O.tx_q_offset_dac <= tx_q;
      CTRL_O.temp_sensor_on <= !sensor_off;
      CTRL_O.temp_conv_on <= !conv_off;
    end
  end

  // a start is ignored when the same write sets the converter off bit
  assign adc_start = wr_en && (ph_addr == bbc_pkg::OFS_TEMP) && HWDATA_I[bbc_pkg::POS_CONV_GO]
                     && !HWDATA_I[bbc_pkg::POS_CONV_OFF];
  assign adc_tick = (adc_state == bbc_pkg::BBC_RUN) && (adc_div == bbc_pkg::ADC_DIV_LAST);
  assign adc_done = adc_tick && (mask == 8'h01);
  assign TEMP_TRIAL_O = trial;
  assign TEMP_SAMPLE_O = adc_tick;

  // successive approximation, one bit per converter clock
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      adc_state <= bbc_pkg::BBC_IDLE;
      adc_div <= 4'h0;
      trial <= bbc_pkg::ADC_FIRST_TRIAL;
      mask <= bbc_pkg::ADC_FIRST_TRIAL;
    end else if (adc_start) begin
      adc_state <= bbc_pkg::BBC_RUN;
      adc_div <= 4'h0;
      trial <= bbc_pkg::ADC_FIRST_TRIAL;
      mask <= bbc_pkg::ADC_FIRST_TRIAL;
    end else begin
      case (adc_state)
        bbc_pkg::BBC_RUN: begin
          adc_div <= adc_div + 4'h1; // wraps at sixteen
          if (adc_tick) begin
            trial <= (TEMP_ABOVE_TRIAL_I ? trial : (trial & ~mask)) | (mask >> 1);
            mask <= mask >> 1;
            if (adc_done) begin
              adc_state <= bbc_pkg::BBC_IDLE;
            end
          end
        end
        default: begin
          adc_state <= bbc_pkg::BBC_IDLE;
        end
      endcase
    end
  end

  // start bit, result and flags; complete clears on a new start, set wins in the same cycle
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      conv_go <= 1'b0;
      temp_result <= 8'h00;
      temp_conv_complete <= 1'b0;
      temp_input_out_of_range <= 1'b0;
    end else begin
      // a finishing conversion still reports, even if a new start lands in the same cycle
      if (adc_start) begin
        conv_go <= 1'b1;
      end else if (adc_done) begin
        conv_go <= 1'b0;
      end
      if (adc_done) begin
        temp_conv_complete <= 1'b1;
        temp_result <= TEMP_ABOVE_TRIAL_I ? trial : (trial & ~mask);
      end else if (adc_start) begin
        temp_conv_complete <= 1'b0;
      end
      if (adc_tick) begin
        temp_input_out_of_range <= TEMP_RANGE_BAD_I;
      end
    end
  end

endmodule : bbc_top

`default_nettype wire

// ===== verification/baseband_cal_and_temp_adc_ctrl_test.sv
// testbench: register bus, calibration and temperature conversion against a bench model
`timescale 1ns/100ps
`default_nettype none
module baseband_cal_and_temp_adc_ctrl_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] tgt = 32'h0;
  logic [7:0] tlev = 8'h0;
  logic tbad = 1'b0;
  logic hready, hresp, above, rbad, smp;
  logic [31:0] hrdata, rd, w, seed, stat;
  logic [3:0] offh, rg;
  logic [7:0] trial, cal_i, cal_q, tv;
  logic [15:0] man;
  bbc_pkg::bbc_ctrl_t ctrl;
  bbc_pkg::bbc_corr_t rxc, xpc;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int t0, d;
  int sels [4] = '{0, 1, 2, 7};
  logic [31:0] rst_val [8] = '{32'h0, 32'h0, 32'h0, 32'h41000000, 32'h00600000, 32'h0, 32'h0,
    32'h00301000};
  logic [31:0] wmask [8] = '{32'h0, 32'h000C0000, 32'h00FF0000, 32'hFFF80000, 32'h00600000,
    32'h3E01F000, 32'h0, 32'h003FFFE0};
  logic [31:0] model [8];

  bbc_top dut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .OFFSET_HIGH_I(offh),
    .TEMP_ABOVE_TRIAL_I(above), .TEMP_RANGE_BAD_I(rbad), .TEMP_TRIAL_O(trial),
    .TEMP_SAMPLE_O(smp), .CTRL_O(ctrl), .RX_CORR_O(rxc), .XPOL_CORR_O(xpc));
  bbc_analog_model fe (.target_i(tgt), .rx_corr_i(rxc), .xpol_corr_i(xpc), .temp_level_i(tlev),
    .temp_bad_i(tbad), .trial_i(trial), .offset_high_o(offh), .above_o(above),
    .range_bad_o(rbad));

  // clock and a cycle count for span checks
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // successive approximation with step floor of one, clamped to the code range
  function automatic logic [7:0] cal_exp(input logic [7:0] t);
    int c, s;
    c = 128;
    s = 64;
    repeat (13) begin
      c = (c > int'(t)) ? c - s : c + s;
      c = (c < 0) ? 0 : ((c > 255) ? 255 : c);
      s = (s > 1) ? s / 2 : 1;
    end
    return 8'(c);
  endfunction : cal_exp

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one single transfer; entered just after a rising edge, read data kept in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== 32'h0 && n < 2000);
  endtask : poll

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog sized well above the longest calibration pair
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h52;
    model = rst_val;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("reset codes", {rxc.i_code, rxc.q_code, xpc.i_code, xpc.q_code}, 32'h80808080);
    // reset values first, then random words written and read back, reserved places included except in the temperature and calibration words
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 8; i++) begin
        bus(1'b0, 8'(i * 4), 32'h0);
        chk("register", rd, model[i]);
        if (r < 2) begin
          w = rnd();
          if (i == 4 || i == 5) w = w & wmask[i];
          bus(1'b1, 8'(i * 4), w);
          if (wmask[i] != 32'h0) model[i] = w & wmask[i];
        end
      end
      chk("controls", 32'(ctrl), 32'({model[2][22:16], model[2][23], model[1][18], model[1][19],
        model[3][31:19], ~model[4][22], ~model[4][21]}));
    end
    // both chains started together with unequal dividers, slowest setting included
    bus(1'b1, 8'h1C, 32'h00200000);
    for (int k = 0; k < 4; k++) begin
      tgt <= rnd();
      rg = 4'(rnd());
      w = 32'h00040020 | (32'(sels[k]) << 14) | (32'(rg[1:0]) << 12) | (32'(sels[3 - k]) << 27)
        | (32'(rg[3:2]) << 25);
      bus(1'b1, 8'h14, w);
      t0 = cyc;
      model[5] = w & wmask[5];
      d = 13 * (2 << ((sels[k] > sels[3 - k]) ? sels[k] : sels[3 - k]));
      bus(1'b0, 8'h14, 32'h0);
      chk("cal busy", rd & 32'h00040020, 32'h00040020);
      poll(8'h14, 32'h00040020);
      chk("cal span", 32'((cyc - t0) >= d && (cyc - t0) <= d + 8), 32'h1);
      chk("cal fields", rd, model[5]);
      cal_i = cal_exp(tgt[7:0]);
      cal_q = cal_exp(tgt[15:8]);
      chk("rx codes", 32'(rxc), 32'({rg[1:0], cal_i, cal_q}));
      chk("xpol codes", 32'(xpc), 32'({rg[3:2], cal_exp(tgt[23:16]),
        cal_exp(tgt[31:24])}));
    end
    // manual codes drive only while the source bit is low, calibrated codes return after
    man = 16'(rnd());
    bus(1'b1, 8'h1C, {10'h0, 1'b0, man, 5'h0});
    repeat (3) @(posedge clk);
    chk("manual codes", 32'({rxc.i_code, rxc.q_code}), 32'({man[7:0], man[15:8]}));
    bus(1'b1, 8'h1C, {10'h0, 1'b1, man, 5'h0});
    repeat (3) @(posedge clk);
    chk("held codes", 32'({rxc.i_code, rxc.q_code}), 32'({cal_i, cal_q}));
    // host corner search: step the code toward the 3 dB point, one write per step
    tv = 8'h38;
    repeat (4) begin
      tv = (tv[6:0] < tgt[6:0]) ? tv + 8'h01 : tv - 8'h01;
      bus(1'b1, 8'h08, {9'h000, tv[6:0], 16'h0000});
      bus(1'b0, 8'h08, 32'h0);
      chk("corner step", rd, {9'h000, tv[6:0], 16'h0000});
    end
    // conversions, the first at full scale
    for (int k = 0; k < 3; k++) begin
      tv = (k == 0) ? 8'hFF : 8'(rnd());
      tlev <= tv;
      tbad <= k[0];
      bus(1'b1, 8'h10, 32'h00000020);
      t0 = cyc;
      poll(8'h10, 32'h20);
      chk("conv span", 32'((cyc - t0) >= 128 && (cyc - t0) <= 136), 32'h1);
      stat = (32'(tv) << 22) | (32'(k[0]) << 6) | 32'h20;
      bus(1'b0, 8'h00, 32'h0);
      chk("temp status", rd, stat);
    end
    // a start with the converter powered down must be ignored
    bus(1'b1, 8'h10, 32'h00200020);
    repeat (150) @(posedge clk);
    bus(1'b0, 8'h10, 32'h0);
    chk("refused start", rd, 32'h00200000);
    bus(1'b0, 8'h00, 32'h0);
    chk("status kept", rd, stat);
    tally_and_finish();
  end
endmodule : baseband_cal_and_temp_adc_ctrl_test
`default_nettype wire

// ===== verification/bbc_analog_model.sv
// partner: offset comparators and temperature converter front end
`timescale 1ns/100ps
`default_nettype none
module bbc_analog_model (
  input wire logic [31:0] target_i,
  input wire bbc_pkg::bbc_corr_t rx_corr_i,
  input wire bbc_pkg::bbc_corr_t xpol_corr_i,
  input wire logic [7:0] temp_level_i,
  input wire logic temp_bad_i,
  input wire logic [7:0] trial_i,
  output logic [3:0] offset_high_o,
  output logic above_o,
  output logic range_bad_o
);
  // oscillator always on, so the comparators answer at every tick
  assign offset_high_o = {xpol_corr_i.q_code > target_i[31:24],
    xpol_corr_i.i_code > target_i[23:16], rx_corr_i.q_code > target_i[15:8],
    rx_corr_i.i_code > target_i[7:0]};
  // steady input level; a slower front end would only delay this compare
  assign above_o = temp_level_i >= trial_i;
  assign range_bad_o = temp_bad_i;
endmodule : bbc_analog_model
`default_nettype wire

// ===== verification/bbc_top_sva.sv
// checker: bus timing, converter tick spacing and control fields of bbc_top
`timescale 1ns/100ps
`default_nettype none
module bbc_top_sva (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic HREADYOUT_O,
  input wire logic [31:0] HRDATA_O,
  input wire logic TEMP_ABOVE_TRIAL_I,
  input wire logic [7:0] TEMP_TRIAL_O,
  input wire logic TEMP_SAMPLE_O,
  input wire bbc_pkg::bbc_ctrl_t CTRL_O
);
  logic taken;
  logic [7:0] ofs;
  // only whole-word writes inside the map count; 8'hFF never decodes
  assign taken = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign ofs = (HWRITE_I && HSIZE_I == 3'h2 && HADDR_I[31:8] == 24'h0) ? HADDR_I[7:0] : 8'hFF;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);
  // bus handshake
  read_wait_a: assert property (taken && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("read wait state wrong");
  write_nowait_a: assert property (taken && HWRITE_I |=> HREADYOUT_O)
    else $error("write stalled");
  rdata_hold_a: assert property (HREADYOUT_O |=> $stable(HRDATA_O))
    else $error("read data moved");
  // converter clock and first approximation step
  adc_tick_gap_a: assert property (
    TEMP_SAMPLE_O |=> !TEMP_SAMPLE_O [*8] ##1 !TEMP_SAMPLE_O [*7]) else $error("ticks too close");
  first_trial_a: assert property (
    TEMP_SAMPLE_O && TEMP_TRIAL_O == bbc_pkg::ADC_FIRST_TRIAL |=>
    TEMP_TRIAL_O == {$past(TEMP_ABOVE_TRIAL_I), 7'h40}) else $error("first trial wrong");
  // control fields follow the written word three edges after the address phase
  corner_code_a: assert property (
    taken && ofs == bbc_pkg::OFS_FILTER |-> ##3
    CTRL_O.rx_filter_corner_code == $past(HWDATA_I[22:16], 2)) else $error("corner wrong");
  bypass_bit_a: assert property (
    taken && ofs == bbc_pkg::OFS_FILTER |-> ##3
    CTRL_O.rx_filter_bypass == $past(HWDATA_I[23], 2)) else $error("bypass wrong");
  sensor_enable_a: assert property (
    taken && ofs == bbc_pkg::OFS_TEMP |-> ##3
    CTRL_O.temp_sensor_on == !$past(HWDATA_I[22], 2)) else $error("sensor enable wrong");
  loopback_bits_a: assert property (
    taken && ofs == bbc_pkg::OFS_LOOPBACK |-> ##3 {CTRL_O.loopback_on,
    CTRL_O.loopback_attenuate} == $past({HWDATA_I[18], HWDATA_I[19]}, 2)) else $error("loopback");
  tx_bias_a: assert property (
    taken && ofs == bbc_pkg::OFS_TXBIAS |-> ##3 {CTRL_O.tx_internal_bias_on,
    CTRL_O.tx_i_offset_dac, CTRL_O.tx_q_offset_dac} == $past(HWDATA_I[31:19], 2))
    else $error("tx bias wrong");
  read_cov: cover property (taken && !HWRITE_I);
  cal_cov: cover property (taken && ofs == bbc_pkg::OFS_CAL);
  tick_cov: cover property (TEMP_SAMPLE_O && TEMP_TRIAL_O == bbc_pkg::ADC_FIRST_TRIAL);
endmodule : bbc_top_sva
bind bbc_top bbc_top_sva chk (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
  .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRDATA_O(HRDATA_O),
  .TEMP_ABOVE_TRIAL_I(TEMP_ABOVE_TRIAL_I), .TEMP_TRIAL_O(TEMP_TRIAL_O),
  .TEMP_SAMPLE_O(TEMP_SAMPLE_O), .CTRL_O(CTRL_O));
`default_nettype wire
